// file: async_timer.sv
// ------------------------------------------------------------
// What this block does
// (RQ1) Timer tick qualifies hclk; oscillator replaces it async
// (RQ2) Software follows safe clock source switch sequence
// (RQ3) Host clock exceeds four times oscillator rate
// (RQ4) Async writes latch after two oscillator rises
// (RQ5) Software waits for transfer before rewriting
// (RQ6) Five independent temporary registers
// (RQ7) Per-register update-busy bits in status
// (RQ8) Compare match suppressed while counter/compare busy
// (RQ9) Software waits busy clear before sleeping
// (RQ10) Software lets one oscillator cycle pass
// (RQ11) Oscillator runs except power-down and standby
// (RQ12) Software waits one second after power-up
// (RQ13) Wake starts on next timer cycle; halt four
// (RQ14) Counter read through copy refreshed per rise
// (RQ15) Software syncs before reading counter after wake
// (RQ16) Async flags delayed three cycles plus tick
// (RQ17) Compare outputs change on timer clock directly
// (RQ18) Source defaults to hclk; select switches oscillator
// (RQ19) Oscillator pins detached while async selected
// (RQ20) Prescaler 1,8,32,64,128,256,1024 or stopped
// (RQ21) Prescaler reset bit restarts prescale phase
// (RQ22) Control A fields laid out, reset zero
// (RQ23) Control A bits 3:2 read zero
// (RQ24) Oscillator crossing passes two flip-flops
// ------------------------------------------------------------
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module async_timer (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clock_enable,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        osc_input_pin,
  input  wire logic        sleep_active,
  input  wire logic [2:0]  sleep_mode,
  output logic             compare_a_out,
  output logic             compare_b_out,
  output logic             osc_enable,
  output logic             port_detach,
  output logic             timer_irq,
  output logic             wake_request,
  output logic             cpu_halt
);

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  async_timer_pkg::bus_phase_t phase;
  logic [7:0] read_value;
  logic       take;

  assign take = hsel && hready && htrans[1] && clock_enable;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      phase <= '0;
    else if (clock_enable && hready)
      phase <= '{valid: take, write: hwrite, addr: haddr[7:0]};
  end

  // Zero wait states; the bus stalls only while the block is frozen
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= clock_enable;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (take && !hwrite)
      hrdata <= {24'h00_0000, read_value};
  end

  logic       wr_valid;
  logic [7:0] wdata;
  assign wr_valid = phase.valid && phase.write && clock_enable;
  assign wdata    = hwdata[7:0];

  // ------------------------------------------------------------
  // Oscillator input crossing
  // ------------------------------------------------------------
  logic osc_meta;
  logic osc_sync;
  logic osc_last;
  logic osc_rise;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_last <= 1'b0;
    end
    else if (clock_enable)
    begin
      osc_meta <= osc_input_pin; // see RQ24
      osc_sync <= osc_meta;
      osc_last <= osc_sync;
    end
  end
  assign osc_rise = osc_sync && !osc_last;

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  logic       async_sel;
  logic [2:0] irq_enable;
  logic [2:0] flags;
  logic       prescaler_rst;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      async_sel  <= 1'b0; // see RQ18
      irq_enable <= 3'h0;
    end
    else if (clock_enable && wr_valid)
    begin
      if (phase.addr == async_timer_pkg::ADDR_ASYNC_STAT)
        async_sel <= wdata[async_timer_pkg::BIT_ASYNC_SEL];
      if (phase.addr == async_timer_pkg::ADDR_IRQ_ENABLE)
        irq_enable <= wdata[2:0];
    end
  end

  // Self-clearing strobe
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      prescaler_rst <= 1'b0;
    else if (clock_enable)
      prescaler_rst <= wr_valid && phase.addr == async_timer_pkg::ADDR_GENERAL &&
                       wdata[async_timer_pkg::BIT_PRESCALER_RST]; // see RQ21
  end

  // ------------------------------------------------------------
  // Temporary registers of the five async targets
  // ------------------------------------------------------------
  logic [7:0] target_addr [async_timer_pkg::NUM_ASYNC];
  logic [7:0] temp_value  [async_timer_pkg::NUM_ASYNC];
  logic [async_timer_pkg::NUM_ASYNC-1:0] busy;
  logic [async_timer_pkg::NUM_ASYNC-1:0] load;

  assign target_addr[async_timer_pkg::IDX_CTRL_B]  = async_timer_pkg::ADDR_CONTROL_B;
  assign target_addr[async_timer_pkg::IDX_CTRL_A]  = async_timer_pkg::ADDR_CONTROL_A;
  assign target_addr[async_timer_pkg::IDX_CMP_B]   = async_timer_pkg::ADDR_COMPARE_B;
  assign target_addr[async_timer_pkg::IDX_CMP_A]   = async_timer_pkg::ADDR_COMPARE_A;
  assign target_addr[async_timer_pkg::IDX_COUNTER] = async_timer_pkg::ADDR_COUNTER;

  genvar gi;
  generate
    for (gi = 0; gi < async_timer_pkg::NUM_ASYNC; gi++)
    begin : g_temp
      logic       hit;
      logic [1:0] edges;
      assign hit = wr_valid && phase.addr == target_addr[gi];

      // A write during a transfer restarts it; software must not do this
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          temp_value[gi] <= async_timer_pkg::RESET_VALUE;
          busy[gi]       <= 1'b0;
          edges          <= 2'h0;
          load[gi]       <= 1'b0;
        end
        else if (clock_enable)
        begin
          load[gi] <= 1'b0;
          if (hit)
          begin
            temp_value[gi] <= wdata; // see RQ6
            busy[gi]       <= async_sel; // see RQ7
            edges          <= 2'h0;
            load[gi]       <= !async_sel;
          end
          else if (busy[gi] && osc_rise)
          begin
            if (edges + 2'h1 == async_timer_pkg::OSC_EDGES_TO_LATCH)
            begin
              busy[gi] <= 1'b0; // see RQ4
              load[gi] <= 1'b1;
            end
            edges <= edges + 2'h1;
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Destination registers
  // ------------------------------------------------------------
  logic [7:0] control_a;
  logic [7:0] control_b;
  logic [7:0] compare_a;
  logic [7:0] compare_b;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      control_a <= async_timer_pkg::RESET_VALUE; // see RQ22
      control_b <= async_timer_pkg::RESET_VALUE;
      compare_a <= async_timer_pkg::RESET_VALUE;
      compare_b <= async_timer_pkg::RESET_VALUE;
    end
    else if (clock_enable)
    begin
      if (load[async_timer_pkg::IDX_CTRL_A])
        control_a <= temp_value[async_timer_pkg::IDX_CTRL_A] &
                     async_timer_pkg::CTRL_A_WRITE_MASK; // see RQ23
      if (load[async_timer_pkg::IDX_CTRL_B])
        control_b <= temp_value[async_timer_pkg::IDX_CTRL_B];
      if (load[async_timer_pkg::IDX_CMP_A])
        compare_a <= temp_value[async_timer_pkg::IDX_CMP_A];
      if (load[async_timer_pkg::IDX_CMP_B])
        compare_b <= temp_value[async_timer_pkg::IDX_CMP_B];
    end
  end

  // ------------------------------------------------------------
  // Source clock and prescaler
  // ------------------------------------------------------------
  logic       source_tick;
  logic [9:0] prescale;
  logic [9:0] div_mask;
  logic       timer_clock_enable;

  assign source_tick = async_sel ? osc_rise : 1'b1; // see RQ1

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      prescale <= 10'h000;
    else if (clock_enable)
    begin
      if (prescaler_rst)
        prescale <= 10'h000; // see RQ21
      else if (source_tick)
        prescale <= prescale + 10'h001;
    end
  end

  always_comb
  begin
    case (control_b[2:0]) // see RQ20
      async_timer_pkg::CS_DIV1:    div_mask = 10'h000;
      async_timer_pkg::CS_DIV8:    div_mask = async_timer_pkg::MASK_DIV8;
      async_timer_pkg::CS_DIV32:   div_mask = async_timer_pkg::MASK_DIV32;
      async_timer_pkg::CS_DIV64:   div_mask = async_timer_pkg::MASK_DIV64;
      async_timer_pkg::CS_DIV128:  div_mask = async_timer_pkg::MASK_DIV128;
      async_timer_pkg::CS_DIV256:  div_mask = async_timer_pkg::MASK_DIV256;
      async_timer_pkg::CS_DIV1024: div_mask = async_timer_pkg::MASK_DIV1024;
      default:                     div_mask = 10'h000;
    endcase
  end

  assign timer_clock_enable = source_tick && !prescaler_rst &&
                              control_b[2:0] != async_timer_pkg::CS_STOP &&
                              (prescale & div_mask) == div_mask;

  // ------------------------------------------------------------
  // Counter, compare and events
  // ------------------------------------------------------------
  logic [7:0] counter;
  logic [7:0] counter_copy;
  logic       match_block;
  logic [2:0] events;

  // Pending counter or compare writes hide the match
  assign match_block = busy[async_timer_pkg::IDX_COUNTER] ||
                       busy[async_timer_pkg::IDX_CMP_A] || busy[async_timer_pkg::IDX_CMP_B];

  always_comb
  begin
    events = 3'h0;
    if (timer_clock_enable)
    begin
      events[async_timer_pkg::BIT_FLAG_OVF]   = counter == 8'hff;
      events[async_timer_pkg::BIT_FLAG_CMP_A] = counter == compare_a && !match_block; // see RQ8
      events[async_timer_pkg::BIT_FLAG_CMP_B] = counter == compare_b && !match_block; // see RQ8
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      counter <= 8'h00;
    else if (clock_enable)
    begin
      if (load[async_timer_pkg::IDX_COUNTER])
        counter <= temp_value[async_timer_pkg::IDX_COUNTER];
      else if (timer_clock_enable)
        counter <= counter + 8'h01;
    end
  end

  // Read copy; after a power-save wake it holds until the next rise
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      counter_copy <= 8'h00;
    else if (clock_enable && (!async_sel || osc_rise))
      counter_copy <= counter; // see RQ14
  end

  // Compare pins follow the tick with no host-side resync
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      compare_a_out <= 1'b0;
      compare_b_out <= 1'b0;
    end
    else if (clock_enable)
    begin
      if (events[async_timer_pkg::BIT_FLAG_CMP_A]) // see RQ17
        case (control_a[async_timer_pkg::POS_COM_A +: 2])
          async_timer_pkg::COM_TOGGLE: compare_a_out <= !compare_a_out;
          async_timer_pkg::COM_CLEAR:  compare_a_out <= 1'b0;
          async_timer_pkg::COM_SET:    compare_a_out <= 1'b1;
          default:                     compare_a_out <= compare_a_out;
        endcase
      if (events[async_timer_pkg::BIT_FLAG_CMP_B]) // see RQ17
        case (control_a[async_timer_pkg::POS_COM_B +: 2])
          async_timer_pkg::COM_TOGGLE: compare_b_out <= !compare_b_out;
          async_timer_pkg::COM_CLEAR:  compare_b_out <= 1'b0;
          async_timer_pkg::COM_SET:    compare_b_out <= 1'b1;
          default:                     compare_b_out <= compare_b_out;
        endcase
    end
  end

  // ------------------------------------------------------------
  // Flag synchronisation
  // ------------------------------------------------------------
  logic [2:0] held;
  logic [2:0] sync_pipe [async_timer_pkg::FLAG_SYNC_STAGES];
  logic [2:0] flag_set;
  logic [2:0] flag_clear;

  // Async events wait one timer cycle, then three host cycles
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      held <= 3'h0;
      for (int i = 0; i < async_timer_pkg::FLAG_SYNC_STAGES; i++)
        sync_pipe[i] <= 3'h0;
    end
    else if (clock_enable)
    begin
      if (!async_sel)
        held <= 3'h0;
      else if (osc_rise)
        held <= events;
      else
        held <= held | events;
      sync_pipe[0] <= (async_sel && osc_rise) ? held : 3'h0; // see RQ16
      for (int i = 1; i < async_timer_pkg::FLAG_SYNC_STAGES; i++)
        sync_pipe[i] <= sync_pipe[i-1];
    end
  end

  assign flag_set   = async_sel ? sync_pipe[async_timer_pkg::FLAG_SYNC_STAGES-1] : events;
  assign flag_clear = (wr_valid && phase.addr == async_timer_pkg::ADDR_FLAGS) ?
                      wdata[2:0] : 3'h0;

  // Write one to clear; a new event wins over the clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flags <= 3'h0;
    else if (clock_enable)
      flags <= (flags & ~flag_clear) | flag_set;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      timer_irq <= 1'b0;
    else if (clock_enable)
      timer_irq <= |(flags & irq_enable);
  end

  // ------------------------------------------------------------
  // Sleep, wake and pins
  // ------------------------------------------------------------
  logic [2:0] halt_count;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wake_request <= 1'b0;
      halt_count   <= 3'h0;
      cpu_halt     <= 1'b0;
    end
    else if (clock_enable)
    begin
      // Wake begins on the timer cycle after the condition
      wake_request <= sleep_active && async_sel && osc_rise &&
                      |(held & irq_enable); // see RQ13
      if (wake_request)
        halt_count <= async_timer_pkg::HALT_CYCLES; // see RQ13
      else if (halt_count != 3'h0)
        halt_count <= halt_count - 3'h1;
      cpu_halt <= wake_request || halt_count > 3'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      osc_enable  <= 1'b0;
      port_detach <= 1'b0;
    end
    else if (clock_enable)
    begin
      osc_enable  <= async_sel && !(sleep_active &&
                     (sleep_mode == async_timer_pkg::SLEEP_POWER_DOWN ||
                      sleep_mode == async_timer_pkg::SLEEP_STANDBY)); // see RQ11
      port_detach <= async_sel; // see RQ19
    end
  end

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  always_comb
  begin
    case (haddr[7:0])
      async_timer_pkg::ADDR_CONTROL_A:  read_value = control_a; // see RQ23
      async_timer_pkg::ADDR_CONTROL_B:  read_value = control_b;
      async_timer_pkg::ADDR_COUNTER:    read_value = counter_copy; // see RQ14
      async_timer_pkg::ADDR_COMPARE_A:  read_value = compare_a;
      async_timer_pkg::ADDR_COMPARE_B:  read_value = compare_b;
      async_timer_pkg::ADDR_ASYNC_STAT: read_value = {2'b00, async_sel, busy[4:0]}; // see RQ7
      async_timer_pkg::ADDR_FLAGS:      read_value = {5'h00, flags};
      async_timer_pkg::ADDR_IRQ_ENABLE: read_value = {5'h00, irq_enable};
      default:                          read_value = 8'h00;
    endcase
  end

endmodule : async_timer

`default_nettype wire

// file: async_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none

module async_timer_bench;
  logic        hclk = 1'b0;
  logic        hresetn;
  logic        clock_enable;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        osc_input_pin = 1'b0;
  logic        osc_run;
  logic        sleep_active;
  logic [2:0]  sleep_mode;
  logic        compare_a_out;
  logic        compare_b_out;
  logic        osc_enable;
  logic        port_detach;
  logic        timer_irq;
  logic        wake_request;
  logic [31:0] rd;
  logic [7:0]  c0;
  int          n_fail;
  int          n_tests;
  int          osc_div;
  int          i;
  int          dv [8] = '{64, 1, 8, 32, 64, 128, 256, 1024};

  async_timer async_timer_inst (
    .hclk(hclk), .hresetn(hresetn), .clock_enable(clock_enable), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .osc_input_pin(osc_input_pin),
    .sleep_active(sleep_active), .sleep_mode(sleep_mode), .compare_a_out(compare_a_out),
    .compare_b_out(compare_b_out), .osc_enable(osc_enable), .port_detach(port_detach),
    .timer_irq(timer_irq), .wake_request(wake_request), .cpu_halt()
  );

  // ------------------------------------------------------------
  // Clocks and bus helpers
  // ------------------------------------------------------------
  always #20 hclk = ~hclk;

  // Oscillator at a tenth of hclk keeps the four-times margin
  always @(posedge hclk)
  begin
    osc_div <= (osc_div == 4) ? 0 : osc_div + 1;
    if (osc_run && osc_div == 4)
      osc_input_pin <= ~osc_input_pin;
  end

  task automatic tally_and_finish(input logic hung);
    if (hung)
      n_fail++;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask : chk

  task automatic chk_range(input logic [7:0] got, input int lo, input int hi);
    n_tests++;
    if ($isunknown(got) || got < lo || got > hi)
    begin
      $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
      n_fail++;
    end
  endtask : chk_range

  task automatic wait_ready;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      k++;
      if (k > 50)
        tally_and_finish(1'b1);
      @(posedge hclk);
    end
  endtask : wait_ready

  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    wait_ready();
    rd = hrdata;
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 8'h00);
    chk(rd, exp);
  endtask : rd_chk

  task automatic wait_idle;
    int k;
    for (k = 0; k < 40; k++)
    begin
      bus(async_timer_pkg::ADDR_ASYNC_STAT, 1'b0, 8'h00);
      if (rd[4:0] === 5'h00)
        return;
    end
    tally_and_finish(1'b1);
  endtask : wait_idle

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    hresetn = 1'b0;
    clock_enable = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = '0;
    osc_run = 1'b0;
    sleep_active = 1'b0;
    sleep_mode = 3'h0;
    n_fail = 0;
    n_tests = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(8'hb0, 32'h0000_0000);
    bus(8'hb0, 1'b1, 8'hff);
    rd_chk(8'hb0, 32'h0000_00f3);
    rd_chk(8'hc4, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);
    chk(hresp, 1'b0);
    bus(8'hb0, 1'b1, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      bus(8'hb4, 1'b1, 8'(c));
      bus(8'hc8, 1'b1, 8'h02);
      bus(8'hb8, 1'b0, 8'h00);
      c0 = rd[7:0];
      repeat (dv[c] * 16) @(posedge hclk);
      bus(8'hb8, 1'b0, 8'h00);
      // Prescaler restarted, so the tick count is exact
      i = c == 0 ? 0 : (c == 1 ? 18 : 16);
      chk_range(rd[7:0] - c0, i, i);
    end
    clock_enable <= 1'b0;
    repeat (4) @(posedge hclk);
    clock_enable <= 1'b1;
    bus(8'hc4, 1'b1, 8'h20);
    osc_run <= 1'b1;
    repeat (3) @(posedge hclk);
    chk(port_detach, 1'b1);
    chk(osc_enable, 1'b1);
    bus(8'hb4, 1'b1, 8'h00);
    wait_idle();
    bus(8'hb8, 1'b1, 8'h55);
    bus(8'hbc, 1'b1, 8'ha7);
    repeat (2) @(posedge hclk);
    rd_chk(8'hc4, 32'h0000_0038);
    wait_idle();
    chk(rd, 32'h0000_0020);
    repeat (30) @(posedge hclk);
    rd_chk(8'hb8, 32'h0000_0055);
    rd_chk(8'hbc, 32'h0000_00a7);
    bus(8'hcc, 1'b1, 8'h07);
    bus(8'hd0, 1'b1, 8'h02);
    bus(8'hbc, 1'b1, 8'h03);
    bus(8'hb0, 1'b1, 8'h50);
    bus(8'hb8, 1'b1, 8'h00);
    bus(8'hb4, 1'b1, 8'h01);
    wait_idle();
    sleep_active <= 1'b1;
    sleep_mode <= 3'h3;
    i = 0;
    while (wake_request !== 1'b1 && i < 400)
    begin
      @(posedge hclk);
      i++;
    end
    if (i >= 400)
      tally_and_finish(1'b1);
    sleep_active <= 1'b0;
    repeat (6) @(posedge hclk);
    chk(timer_irq, 1'b1);
    chk(compare_a_out, 1'b1);
    chk(compare_b_out, 1'b1);
    bus(8'hcc, 1'b0, 8'h00);
    chk(rd & 32'h0000_0002, 32'h0000_0002);
    bus(8'hb0, 1'b1, 8'h50);
    wait_idle();
    bus(8'hb8, 1'b0, 8'h00);
    chk_range(rd[7:0], 4, 40);
    sleep_active <= 1'b1;
    sleep_mode <= async_timer_pkg::SLEEP_POWER_DOWN;
    repeat (3) @(posedge hclk);
    chk(osc_enable, 1'b0);
    sleep_mode <= async_timer_pkg::SLEEP_STANDBY;
    repeat (3) @(posedge hclk);
    chk(osc_enable, 1'b0);
    sleep_active <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(osc_enable, 1'b1);
    bus(8'hc4, 1'b1, 8'h00);
    repeat (3) @(posedge hclk);
    chk(port_detach, 1'b0);
    tally_and_finish(1'b0);
  end
endmodule : async_timer_bench

`default_nettype wire

// file: async_timer_chk.sv
`timescale 1ns/1ps
`default_nettype none

module async_timer_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        clock_enable,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        sleep_active,
  input wire logic [2:0]  sleep_mode,
  input wire logic        compare_a_out,
  input wire logic        compare_b_out,
  input wire logic        osc_enable,
  input wire logic        port_detach,
  input wire logic        wake_request,
  input wire logic        cpu_halt
);
  // ------------------------------------------------------------
  // Port relations
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic deep;
  logic rd_ctrl_a;

  assign deep = sleep_active && (sleep_mode == async_timer_pkg::SLEEP_POWER_DOWN
                || sleep_mode == async_timer_pkg::SLEEP_STANDBY);
  assign rd_ctrl_a = hsel && hready && htrans[1] && !hwrite && clock_enable
                     && haddr[7:0] == async_timer_pkg::ADDR_CONTROL_A;

  a_osc_deep_off: assert property (deep |=> !osc_enable)
    else $error("oscillator on in deep sleep");
  a_osc_runs_save: assert property (port_detach && $past(port_detach) && !$past(deep) |-> osc_enable)
    else $error("oscillator off while selected");
  a_osc_needs_sel: assert property (osc_enable |-> port_detach)
    else $error("oscillator on with pins attached");
  a_wake_pulse: assert property (wake_request |=> !wake_request)
    else $error("wake request longer than one cycle");
  a_halt_four: assert property (wake_request |=> cpu_halt [*4] ##1 !cpu_halt)
    else $error("halt not four cycles after wake");
  a_halt_cause: assert property ($rose(cpu_halt) |-> $past(wake_request))
    else $error("halt without wake");
  a_ctrl_a_read: assert property (rd_ctrl_a |=> hrdata[31:8] == '0 && hrdata[3:2] == 2'b00)
    else $error("control a reserved bits not zero");
  a_frozen_state: assert property (!clock_enable |=> !hreadyout && $stable(compare_a_out)
                                   && $stable(compare_b_out))
    else $error("state moved while enable low");

  c_wake: cover property (wake_request);
  c_osc_run: cover property (osc_enable && !sleep_active);
  c_ctrl_a_read: cover property (rd_ctrl_a);
endmodule : async_timer_chk

bind async_timer async_timer_chk async_timer_chk_inst (
  .hclk(hclk), .hresetn(hresetn), .clock_enable(clock_enable), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .sleep_active(sleep_active), .sleep_mode(sleep_mode), .compare_a_out(compare_a_out),
  .compare_b_out(compare_b_out), .osc_enable(osc_enable), .port_detach(port_detach),
  .wake_request(wake_request), .cpu_halt(cpu_halt)
);

`default_nettype wire

// file: async_timer_pkg.sv
package async_timer_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL_A   = 8'hb0;
  localparam logic [7:0] ADDR_CONTROL_B   = 8'hb4;
  localparam logic [7:0] ADDR_COUNTER     = 8'hb8;
  localparam logic [7:0] ADDR_COMPARE_A   = 8'hbc;
  localparam logic [7:0] ADDR_COMPARE_B   = 8'hc0;
  localparam logic [7:0] ADDR_ASYNC_STAT  = 8'hc4;
  localparam logic [7:0] ADDR_GENERAL     = 8'hc8;
  localparam logic [7:0] ADDR_FLAGS       = 8'hcc;
  localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'hd0;

  // ------------------------------------------------------------
  // Asynchronously written registers, index into the temp array
  // ------------------------------------------------------------
  localparam int NUM_ASYNC   = 5;
  localparam int IDX_CTRL_B  = 0;
  localparam int IDX_CTRL_A  = 1;
  localparam int IDX_CMP_B   = 2;
  localparam int IDX_CMP_A   = 3;
  localparam int IDX_COUNTER = 4;

  // ------------------------------------------------------------
  // Fields
  // ------------------------------------------------------------
  localparam int BIT_ASYNC_SEL     = 5;
  localparam int BIT_PRESCALER_RST = 1;
  localparam int BIT_FLAG_OVF      = 0;
  localparam int BIT_FLAG_CMP_A    = 1;
  localparam int BIT_FLAG_CMP_B    = 2;
  localparam int POS_COM_A         = 6;
  localparam int POS_COM_B         = 4;
  localparam logic [7:0] CTRL_A_WRITE_MASK = 8'hf3;
  localparam logic [7:0] RESET_VALUE       = 8'h00;

  // Compare output actions
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  // Clock select codes in control_b[2:0]
  localparam logic [2:0] CS_STOP  = 3'h0;
  localparam logic [2:0] CS_DIV1  = 3'h1;
  localparam logic [2:0] CS_DIV8  = 3'h2;
  localparam logic [2:0] CS_DIV32 = 3'h3;
  localparam logic [2:0] CS_DIV64 = 3'h4;
  localparam logic [2:0] CS_DIV128 = 3'h5;
  localparam logic [2:0] CS_DIV256 = 3'h6;
  localparam logic [2:0] CS_DIV1024 = 3'h7;
  localparam logic [9:0] MASK_DIV8    = 10'h007;
  localparam logic [9:0] MASK_DIV32   = 10'h01f;
  localparam logic [9:0] MASK_DIV64   = 10'h03f;
  localparam logic [9:0] MASK_DIV128  = 10'h07f;
  localparam logic [9:0] MASK_DIV256  = 10'h0ff;
  localparam logic [9:0] MASK_DIV1024 = 10'h3ff;

  // Sleep modes seen on the sleep_mode input
  localparam logic [2:0] SLEEP_POWER_DOWN = 3'h2;
  localparam logic [2:0] SLEEP_STANDBY    = 3'h6;

  // ------------------------------------------------------------
  // Timing counts
  // ------------------------------------------------------------
  localparam logic [1:0] OSC_EDGES_TO_LATCH = 2'h2;
  localparam int         FLAG_SYNC_STAGES   = 3;
  localparam logic [2:0] HALT_CYCLES        = 3'h4;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } bus_phase_t;

endpackage : async_timer_pkg
